/* File: verilog/dsf_consts.vh */
// Constants for the result-status flag block of the disk controller.
// Assumes a single 100 MHz core clock and a plain strobed register port.
//
// Functional notes
// - Overrun flag, byte 1 bit 4, set when host misses a transfer.
// - Byte 1 bit 3 always reads zero.
// - No-data flag set when requested sector not found in read, write-deleted, scan.
// - Missing data mark sets byte 1 bit 0 and byte 2 bit 0 together.
// - Byte 2 bit 7 always reads zero.
// - Data-field CRC flag set when data field CRC check fails.
// - Wrong-cylinder flag set with no-data when medium cylinder mismatches.
// - Scan-equal-hit flag set in scan when equality condition met.
// - Scan-not-satisfied flag set when no sector meets scan condition.
// - Bad-cylinder flag set with no-data when mismatched medium cylinder is ff.
// - Data-field missing-mark flag set when data read finds no data mark.
// - Byte 3 bit 7 shows drive fault input level.
// - Byte 3 shows write protect, ready, track zero, two-sided in bits 6..3.
// - Byte 3 shows side select and two unit selects in bits 2..0.
// - End-of-cylinder flag, byte 1 bit 7, set past last sector.
// - Data error flag, byte 1 bit 5, on any CRC failure; bit 6 zero.
`ifndef DSF_CONSTS_VH
`define DSF_CONSTS_VH

// Register indices on the local port.
`define DSF_ADDR_ST1 2'h1
`define DSF_ADDR_ST2 2'h2
`define DSF_ADDR_ST3 2'h3
`define DSF_ADDR_CUR 2'h0

// Status byte 1 field positions.
`define DSF_ST1_EOC 7
`define DSF_ST1_DE 5
`define DSF_ST1_OVR 4
`define DSF_ST1_ND 2
`define DSF_ST1_NW 1
`define DSF_ST1_MA 0

// Status byte 2 field positions.
`define DSF_ST2_CM 6
`define DSF_ST2_DD 5
`define DSF_ST2_WC 4
`define DSF_ST2_SH 3
`define DSF_ST2_SN 2
`define DSF_ST2_BC 1
`define DSF_ST2_MD 0

// Reset value of flag bytes and the bad cylinder marker.
`define DSF_FLAGS_RESET 8'h00
`define DSF_BAD_CYL 8'hff

// Command classes from the sequencer.
`define DSF_CMD_READ 3'h0
`define DSF_CMD_READ_DEL 3'h1
`define DSF_CMD_WRITE 3'h2
`define DSF_CMD_WRITE_DEL 3'h3
`define DSF_CMD_FORMAT 3'h4
`define DSF_CMD_SCAN 3'h5
`define DSF_CMD_READ_ID 3'h6
`define DSF_CMD_OTHER 3'h7

// Index pulses allowed before the identifier mark is called missing.
`define DSF_INDEX_LIMIT 2'h2

`endif

/* File: verilog/dsf_status_byte.v */
// One sticky status byte: bits set by hardware events, cleared together.
// Assumes set pulses and the clear are synchronous to core_clk.
`timescale 1ns/1ps
module dsf_status_byte #(
	parameter WIDTH = 8,
	parameter [WIDTH-1:0] ZERO_MASK = 8'h00
) (
	input wire core_clk,
	input wire sys_rst,
	input wire clear,
	input wire [WIDTH-1:0] set,
	output reg [WIDTH-1:0] value
);

////////////////////////////////////////////////////////////////////////////
// A set arriving with the clear wins, so a fresh event is never lost.
genvar i;
generate
	for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
		always @(posedge core_clk) begin
			if (sys_rst || ZERO_MASK[i]) begin
				value[i] <= 1'b0;
			end else if (set[i]) begin
				value[i] <= 1'b1;
			end else if (clear) begin
				value[i] <= 1'b0;
			end
		end
	end
endgenerate

endmodule

/* File: verilog/dsf_status_flags.v */
// Result-status flag logic: forms status bytes 1, 2 and 3.
// Assumes event inputs are one-cycle pulses from the command sequencer,
// CRC checker, mark detector and scan comparator, all on core_clk.
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "dsf_consts.vh"
module dsf_status_flags (
	input wire core_clk,
	input wire sys_rst,
	input wire cmd_start,
	input wire [2:0] cmd_class,
	input wire overrun_event,
	input wire sector_not_found,
	input wire id_crc_fail,
	input wire data_crc_fail,
	input wire id_mark_found,
	input wire index_pulse,
	input wire data_mark_missing,
	input wire deleted_mark_seen,
	input wire cylinder_end_event,
	input wire write_attempt,
	input wire [7:0] medium_cylinder,
	input wire [7:0] id_register_cyl,
	input wire scan_equal_event,
	input wire scan_done_no_match,
	input wire drive_fault_status,
	input wire write_protect_in,
	input wire ready_in,
	input wire track_zero_status,
	input wire two_sided_status,
	input wire side_select_status,
	input wire unit_select_high,
	input wire unit_select_low,
	input wire [1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [7:0] reg_rdata,
	output wire [7:0] transfer_error_status,
	output wire [7:0] data_field_scan_status,
	output reg [7:0] drive_signal_status
);

////////////////////////////////////////////////////////////////////////////
// Command class latched at command start; it qualifies the flag sources.
reg [2:0] cur_class;
reg [1:0] index_count;
reg [7:0] set1;
reg [7:0] set2;
wire is_read;
wire is_scan;
wire is_write;
wire cyl_mismatch;
wire no_data_flag;

// Software may also force the class through a write; the sequencer port
// normally owns it, and a cmd_start in the same cycle takes priority.
always @(posedge core_clk) begin
	if (sys_rst) begin
		cur_class <= `DSF_CMD_OTHER;
	end else if (cmd_start) begin
		cur_class <= cmd_class;
	end else if (reg_write && reg_addr == `DSF_ADDR_CUR) begin
		cur_class <= reg_wdata[2:0];
	end
end

assign is_read = (cur_class == `DSF_CMD_READ) ||
	(cur_class == `DSF_CMD_READ_DEL);
assign is_scan = (cur_class == `DSF_CMD_SCAN);
assign is_write = (cur_class == `DSF_CMD_WRITE) ||
	(cur_class == `DSF_CMD_WRITE_DEL) ||
	(cur_class == `DSF_CMD_FORMAT);
assign cyl_mismatch = (medium_cylinder != id_register_cyl);

////////////////////////////////////////////////////////////////////////////
// Index pulses seen without an identifier mark; saturates at the limit.
always @(posedge core_clk) begin
	if (sys_rst || cmd_start || id_mark_found) begin
		index_count <= 2'h0;
	end else if (index_pulse && index_count != `DSF_INDEX_LIMIT) begin
		index_count <= index_count + 2'h1;
	end
end

// No-data condition, shared by byte 1 and the cylinder flags of byte 2.
// Read deleted data is left out on purpose: only plain read data, write
// deleted data and scan report a missing sector here.
assign no_data_flag = (sector_not_found &&
	(cur_class == `DSF_CMD_READ || is_scan ||
	cur_class == `DSF_CMD_WRITE_DEL)) ||
	(cur_class == `DSF_CMD_READ_ID && id_crc_fail);

////////////////////////////////////////////////////////////////////////////
// Set terms of status byte 1.
always @* begin
	set1 = 8'h00;
	set1[`DSF_ST1_EOC] = cylinder_end_event;
	set1[`DSF_ST1_DE] = id_crc_fail || data_crc_fail;
	set1[`DSF_ST1_OVR] = overrun_event;
	set1[`DSF_ST1_ND] = no_data_flag;
	set1[`DSF_ST1_NW] = is_write && write_attempt && write_protect_in;
	// Second index pulse with no mark, or a missing data mark.
	set1[`DSF_ST1_MA] = (index_pulse && !id_mark_found &&
		index_count == `DSF_INDEX_LIMIT - 2'h1) ||
		data_mark_missing;
end

// Set terms of status byte 2.
always @* begin
	set2 = 8'h00;
	set2[`DSF_ST2_CM] = (cur_class == `DSF_CMD_READ || is_scan) &&
		deleted_mark_seen;
	set2[`DSF_ST2_DD] = data_crc_fail;
	set2[`DSF_ST2_WC] = no_data_flag && cyl_mismatch;
	set2[`DSF_ST2_SH] = is_scan && scan_equal_event;
	set2[`DSF_ST2_SN] = is_scan && scan_done_no_match;
	set2[`DSF_ST2_BC] = no_data_flag && cyl_mismatch &&
		medium_cylinder == `DSF_BAD_CYL;
	set2[`DSF_ST2_MD] = data_mark_missing;
end

////////////////////////////////////////////////////////////////////////////
// Sticky bytes; bits 6 and 3 of byte 1 and bit 7 of byte 2 stay zero.
dsf_status_byte #(
	.WIDTH(8),
	.ZERO_MASK(8'h48)
) u_st1 (
	.core_clk(core_clk),
	.sys_rst(sys_rst),
	.clear(cmd_start),
	.set(set1),
	.value(transfer_error_status)
);

dsf_status_byte #(
	.WIDTH(8),
	.ZERO_MASK(8'h80)
) u_st2 (
	.core_clk(core_clk),
	.sys_rst(sys_rst),
	.clear(cmd_start),
	.set(set2),
	.value(data_field_scan_status)
);

////////////////////////////////////////////////////////////////////////////
// Byte 3 follows the drive lines with one cycle of delay.
always @(posedge core_clk) begin
	if (sys_rst) begin
		drive_signal_status <= `DSF_FLAGS_RESET;
	end else begin
		drive_signal_status <= {drive_fault_status,
			write_protect_in, ready_in, track_zero_status,
			two_sided_status,
			side_select_status, unit_select_high,
			unit_select_low};
	end
end

////////////////////////////////////////////////////////////////////////////
// Read port: data valid the cycle after the strobe, zero otherwise.
always @(posedge core_clk) begin
	if (sys_rst || !reg_read) begin
		reg_rdata <= 8'h00;
	end else begin
		case (reg_addr)
			`DSF_ADDR_ST1: reg_rdata <= transfer_error_status;
			`DSF_ADDR_ST2: reg_rdata <= data_field_scan_status;
			`DSF_ADDR_ST3: reg_rdata <= drive_signal_status;
			default: reg_rdata <= {5'h00, cur_class};
		endcase
	end
end

endmodule

/* File: bench/dsf_drive_model.sv */
// Drive model: fault, protect, ready, track 0 and two-side levels.
// Assumes only the core clock; levels move every eighth cycle.
`timescale 1ns/1ps
module dsf_drive_model (
	input wire core_clk,
	output reg [4:0] lines = 5'h00
);
	reg [7:0] n = 8'h00;
	// Slow changes, as a mechanism makes, so mirrored bits are seen settled.
	always @(posedge core_clk) begin
		n <= n + 8'h01;
		if (n[2:0] == 3'h7)
			lines <= n[7:3] ^ n[4:0];
	end
endmodule

/* File: bench/dsf_status_flags_chk.sv */
// Checker: status flags against their causes at the block's ports.
// Assumes it is bound into the flag block on the one core clock.
`timescale 1ns/1ps
module dsf_status_flags_chk (
	input wire core_clk,
	input wire sys_rst,
	input wire cmd_start,
	input wire overrun_event,
	input wire data_crc_fail,
	input wire drive_fault_status,
	input wire write_protect_in,
	input wire [7:0] transfer_error_status,
	input wire [7:0] data_field_scan_status,
	input wire [7:0] drive_signal_status
);
	// Short views of the three bytes keep the properties readable.
	wire [7:0] s1 = transfer_error_status;
	wire [7:0] s2 = data_field_scan_status;
	wire [7:0] s3 = drive_signal_status;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	a_spare_st1: assert property (!s1[3] && !s1[6])
		else $error("spare bit set in byte 1");
	a_spare_st2: assert property (!s2[7])
		else $error("spare bit set in byte 2");
	a_overrun_set: assert property (overrun_event |=> s1[4])
		else $error("overrun flag not set");
	a_crc_pair: assert property (data_crc_fail |=> s1[5] && s2[5])
		else $error("crc flags not set");
	a_mark_pair: assert property ($rose(s2[0]) |-> s1[0])
		else $error("mark flags not paired");
	a_overrun_sticky: assert property (!cmd_start && s1[4] |=> s1[4])
		else $error("overrun flag lost");
	a_start_clear: assert property
		(cmd_start |=> s1[4] == $past(overrun_event))
		else $error("flag survived a new command");
	a_drive_lag: assert property (1'b1 |=>
		$past(drive_fault_status) == s3[7] &&
		$past(write_protect_in) == s3[6])
		else $error("drive lines not mirrored");
	c_scan_hit: cover property (s2[3]);
	c_bad_cyl: cover property (s2[1]);
	c_no_data: cover property (s1[2]);
endmodule
////////////////////////////////////////////////////////////////////////
bind dsf_status_flags dsf_status_flags_chk chk (.core_clk, .sys_rst,
	.cmd_start, .overrun_event, .data_crc_fail, .drive_fault_status,
	.write_protect_in, .transfer_error_status, .data_field_scan_status,
	.drive_signal_status);

/* File: bench/dsf_status_flags_tb.sv */
// Bench: random events, drive levels and reads against a flag model.
// Assumes the drive model supplies the five drive-side levels.
`timescale 1ns/1ps
module dsf_status_flags_tb;
	reg core_clk = 1'b0, sys_rst = 1'b1, cs = 1'b0, rr = 1'b0, rw = 1'b0;
	reg [11:0] e = 12'h000;
	reg [2:0] cls = 3'h0, hs = 3'h0, cl = 3'h7;
	reg [1:0] ra = 2'h0;
	reg [7:0] mc = 8'h00, ic = 8'h00, wd = 8'h00;
	reg [7:0] m1 = 8'h00, m2 = 8'h00, m3, xr;
	reg [31:0] s = 32'h000076ce, r, q;
	reg nd, wc;
	wire [4:0] dl;
	wire [7:0] rd, s1, s2, s3;
	integer fail_count = 0, checked = 0, n = 0, i;
	dsf_drive_model drv (.core_clk(core_clk), .lines(dl));
	dsf_status_flags dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.cmd_start(cs), .cmd_class(cls), .overrun_event(e[0]),
		.sector_not_found(e[1]), .id_crc_fail(e[2]), .data_crc_fail(e[3]),
		.id_mark_found(e[4]), .index_pulse(e[5]), .data_mark_missing(e[6]),
		.deleted_mark_seen(e[7]), .cylinder_end_event(e[8]),
		.write_attempt(e[9]), .scan_equal_event(e[10]),
		.scan_done_no_match(e[11]), .medium_cylinder(mc),
		.id_register_cyl(ic), .drive_fault_status(dl[4]),
		.write_protect_in(dl[3]), .ready_in(dl[2]), .track_zero_status(dl[1]),
		.two_sided_status(dl[0]), .side_select_status(hs[2]),
		.unit_select_high(hs[1]), .unit_select_low(hs[0]), .reg_addr(ra),
		.reg_wdata(wd), .reg_write(rw), .reg_read(rr), .reg_rdata(rd),
		.transfer_error_status(s1), .data_field_scan_status(s2),
		.drive_signal_status(s3));
	// Xorshift source; every call advances the shared state.
	function logic [31:0] rnd();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction
	// Model the edge just taken, then drive the next cycle's inputs.
	task step;
		xr = rr ? {m3, m2, m1, 5'h00, cl} >> {ra, 3'h0} : 8'h00;
		m3 = {dl, hs};
		nd = e[1] && (cl == 3'h0 || cl == 3'h3 || cl == 3'h5) ||
			e[2] && cl == 3'h6;
		wc = nd && mc != ic;
		n = cs || e[4] ? 0 : n + e[5];
		m1 = cs ? 8'h00 : m1 | {e[8], 1'b0, e[2] | e[3], e[0], 1'b0, nd,
			e[9] && dl[3] && cl > 3'h1 && cl < 3'h5, e[6] || n > 1};
		m2 = cs ? 8'h00 : m2 | {1'b0, e[7], e[3], wc, e[10] && cl == 3'h5,
			e[11] && cl == 3'h5, wc && mc == 8'hff, e[6]};
		if (cs) cl = cls;
		else if (rw && ra == 2'h0) cl = wd[2:0];
		r = rnd();
		q = rnd() & rnd() & rnd();
		// Events never share a cycle with a new command.
		if (r[3:0] == 4'h0 || i == 0) q = 32'h0;
		if (q[4]) q[5] = 1'b0;
		if (cl != 3'h0 && cl != 3'h5) q[7:6] = 2'h0;
		cs <= r[3:0] == 4'h0 || i == 0;
		cls <= r[6:4] == 3'h1 ? 3'h7 : r[6:4];
		e <= q[11:0];
		mc <= r[17:16] == 2'h0 ? 8'hff : r[17:16] == 2'h1 ? r[15:8] : r[25:18];
		{ra, rr, hs, wd, ic} <= {r[31:26], r[23:8]};
		rw <= !r[29] && (r[31:30] != 2'h0 || r[7:4] == 4'h3);
	endtask
	task cmp(input [7:0] g, x);
		checked = checked + 1;
		if (g !== x) begin
			fail_count = fail_count + 1;
			$display("[ERR] %0t got %h expected %h", $time, g, x);
		end
	endtask
	task final_report;
		if (fail_count == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial forever #5 core_clk = ~core_clk;
	// Twelve reset edges, then a bounded random run.
	initial begin
		repeat (12) @(posedge core_clk);
		sys_rst <= 1'b0;
		for (i = 0; i < 5000; i = i + 1) begin
			@(posedge core_clk);
			step;
			#1 cmp(s1, m1); // Byte 1.
			cmp(s2, m2); // Byte 2.
			cmp(s3, m3); // Byte 3.
			cmp(rd, xr); // Read port.
		end
		final_report;
	end
endmodule
